// file: hdl/prt_core.sv
`timescale 1ns/1ps

// Operation
// - after power-up delay, light every segment for about two seconds
// - then show firmware identifier and version for about two seconds
// - then start rate display and totalising with stored calibration
// - count one pulse source, show scaled total and rate together
// - commit plus down held shows low eight grand total digits, indicator lit
// - commit plus up held shows high eight grand total digits, indicator lit
// - with local reset enabled, up plus down over two seconds clears total
// - down plus function held shows firmware identifier and version
// - with alarms fitted, button combinations may be remapped by configuration
// - rate shown on a six digit display
// - total shown on eight digits, zeroed by local or remote reset
// - each pulse animates the flow indicator for two seconds
// - hold indicator lit while input frequency is below clip-off
// - reset indicator lit while a total reset is in progress
// - only one input terminal pair supplies pulses at a time
// - remote reset closed over one second zeroes the total
// - remote reset held closed halts totalisation as an inhibit
// - totalising continues during programming or calibration
// - rate is frequency over rate divisor times 1, 60 or 3600
// - total is count over divisor, updated twice a second, feeds grand total
module prt_core #(
  parameter int unsigned START_DELAY_MS_P  = prt_pkg::START_DELAY_MS,
  parameter int unsigned TICK_CYCLES_P     = prt_pkg::TICK_CYCLES,
  parameter int unsigned RATE_DIGITS       = 6,
  parameter int unsigned TOTAL_DIGITS      = 8
) (
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  input  wire logic                 pulse_in,
  input  wire logic                 remote_reset,
  input  wire prt_pkg::prt_buttons_t buttons,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  output logic      [31:0]          rate_display,
  output logic      [31:0]          total_display,
  output prt_pkg::prt_annun_t       annunciators,
  output logic                      running
);

  // ****************************************************************
  // millisecond tick
  // ****************************************************************
  logic [31:0]         tick_cnt_reg;
  logic                ms_tick;
  prt_pkg::prt_phase_t phase_reg;
  logic [31:0]         phase_ms_reg;

  // one ms enable pulse; all timers count these
  always_ff @(posedge ref_clk)
  begin
    if (rst || tick_cnt_reg == TICK_CYCLES_P - 1)
      tick_cnt_reg <= 32'h0;
    else
      tick_cnt_reg <= tick_cnt_reg + 32'h1;
  end
  assign ms_tick = (tick_cnt_reg == TICK_CYCLES_P - 1);

  // ****************************************************************
  // initialisation sequence
  // ****************************************************************
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      phase_reg    <= prt_pkg::PRT_PWR_WAIT;
      phase_ms_reg <= 32'h0;
    end
    else if (ms_tick)
    begin
      phase_ms_reg <= phase_ms_reg + 32'h1;
      unique case (phase_reg)
        prt_pkg::PRT_PWR_WAIT:
          if (phase_ms_reg >= START_DELAY_MS_P - 1)
          begin
            phase_reg    <= prt_pkg::PRT_SEG_TEST;
            phase_ms_reg <= 32'h0;
          end
        prt_pkg::PRT_SEG_TEST:
          if (phase_ms_reg >= prt_pkg::SEG_TEST_MS - 1)
          begin
            phase_reg    <= prt_pkg::PRT_FW_SHOW;
            phase_ms_reg <= 32'h0;
          end
        prt_pkg::PRT_FW_SHOW:
          if (phase_ms_reg >= prt_pkg::FW_SHOW_MS - 1)
            phase_reg <= prt_pkg::PRT_RUN;
        prt_pkg::PRT_RUN:
          phase_ms_reg <= 32'h0;
        default:
          phase_reg <= prt_pkg::PRT_PWR_WAIT;
      endcase
    end
  end
  assign running = (phase_reg == prt_pkg::PRT_RUN);

  // ****************************************************************
  // registers over apb
  // ****************************************************************
  logic [31:0] ctrl_reg;
  logic [31:0] rate_div_reg;
  logic [31:0] total_div_reg;
  logic [31:0] clip_reg;
  logic [31:0] btn_map_reg;
  logic        wr_en;
  logic        gt_clr;

  assign pready  = 1'b1; // zero wait states
  assign wr_en   = psel && penable && pwrite;
  assign gt_clr  = wr_en && paddr == prt_pkg::CTRL_OFS && pwdata[prt_pkg::CTRL_GT_CLR_BIT];

  // calibration store; divisors of zero are forced to one to avoid divide by zero
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      ctrl_reg      <= prt_pkg::CTRL_RESET;
      rate_div_reg  <= prt_pkg::DIV_RESET;
      total_div_reg <= prt_pkg::DIV_RESET;
      clip_reg      <= prt_pkg::CLIP_RESET;
      btn_map_reg   <= prt_pkg::BTN_MAP_RESET;
    end
    else if (wr_en)
    begin
      unique case (paddr)
        prt_pkg::CTRL_OFS:      ctrl_reg      <= pwdata & 32'h0000_0037; // clear bit self-clears
        prt_pkg::RATE_DIV_OFS:  rate_div_reg  <= (pwdata == 32'h0) ? prt_pkg::DIV_RESET : pwdata;
        prt_pkg::TOTAL_DIV_OFS: total_div_reg <= (pwdata == 32'h0) ? prt_pkg::DIV_RESET : pwdata;
        prt_pkg::CLIP_OFS:      clip_reg      <= pwdata;
        prt_pkg::BTN_MAP_OFS:   btn_map_reg   <= pwdata;
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // button decode with optional remap
  // ****************************************************************
  prt_pkg::prt_buttons_t btn;
  logic show_gt_lo, show_gt_hi, show_fw, loc_combo;

  // alarms fitted: map register swaps up/down and commit/function pairs
  always_comb
  begin
    btn = buttons;
    if (ctrl_reg[prt_pkg::CTRL_ALARM_BIT] && btn_map_reg[0])
    begin
      btn.up     = buttons.down;
      btn.down   = buttons.up;
      btn.commit = buttons.func;
      btn.func   = buttons.commit;
    end
  end
  assign show_gt_lo = running && btn.commit && btn.down && !btn.up;
  assign show_gt_hi = running && btn.commit && btn.up && !btn.down;
  assign show_fw    = running && btn.down && btn.func && !btn.commit;
  assign loc_combo  = running && btn.up && btn.down && !btn.commit && !btn.func;

  // ****************************************************************
  // reset timers
  // ****************************************************************
  logic [31:0] loc_ms_reg, rem_ms_reg;
  logic        loc_fire, rem_fire, reset_busy;

  always_ff @(posedge ref_clk)
  begin
    if (rst || !(loc_combo && ctrl_reg[prt_pkg::CTRL_LOC_RST_BIT]))
      loc_ms_reg <= 32'h0;
    else if (ms_tick && loc_ms_reg <= prt_pkg::LOCAL_RESET_MS)
      loc_ms_reg <= loc_ms_reg + 32'h1;
  end
  always_ff @(posedge ref_clk)
  begin
    if (rst || !remote_reset)
      rem_ms_reg <= 32'h0;
    else if (ms_tick && rem_ms_reg <= prt_pkg::REMOTE_RESET_MS)
      rem_ms_reg <= rem_ms_reg + 32'h1;
  end
  assign loc_fire   = loc_ms_reg > prt_pkg::LOCAL_RESET_MS;
  assign rem_fire   = rem_ms_reg > prt_pkg::REMOTE_RESET_MS;
  assign reset_busy = loc_fire || rem_fire;

  // ****************************************************************
  // pulse counting
  // ****************************************************************
  logic pulse_d_reg, pulse_edge;
  logic [31:0] pend_cnt_reg, total_frac_reg, total_reg, gate_ms_reg, gate_cnt_reg;
  logic [31:0] freq_reg, upd_ms_reg, flow_ms_reg;
  logic [63:0] grand_reg;
  logic        hold;

  // single input only; terminal selection is outside this logic
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      pulse_d_reg <= 1'b0;
    else
      pulse_d_reg <= pulse_in;
  end
  assign pulse_edge = pulse_in && !pulse_d_reg;

  assign hold = running && (freq_reg < clip_reg);

  // raw pulses since the last fold; inhibited by held remote contact or clip-off
  always_ff @(posedge ref_clk)
  begin
    if (rst || reset_busy)
      pend_cnt_reg <= 32'h0;
    else if (ms_tick && upd_ms_reg == prt_pkg::TOTAL_UPDATE_MS - 1)
      pend_cnt_reg <= {31'h0, pulse_edge && running && !remote_reset && !hold};
    else if (pulse_edge && running && !remote_reset && !hold)
      pend_cnt_reg <= pend_cnt_reg + 32'h1;
  end

  // twice per second fold pending pulses into total and grand total
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      upd_ms_reg <= 32'h0;
    else if (ms_tick)
      upd_ms_reg <= (upd_ms_reg == prt_pkg::TOTAL_UPDATE_MS - 1) ? 32'h0 : upd_ms_reg + 32'h1;
  end

  // integer division per update keeps the remainder in total_frac_reg
  always_ff @(posedge ref_clk)
  begin
    if (rst || reset_busy)
    begin
      total_frac_reg <= 32'h0;
      total_reg      <= 32'h0;
    end
    else if (ms_tick && upd_ms_reg == prt_pkg::TOTAL_UPDATE_MS - 1)
    begin
      total_reg      <= total_reg + (pend_cnt_reg + total_frac_reg) / total_div_reg;
      total_frac_reg <= (pend_cnt_reg + total_frac_reg) % total_div_reg;
    end
  end

  // grand total tracks every total increment; clear bit wins only by software
  always_ff @(posedge ref_clk)
  begin
    if (rst || gt_clr)
      grand_reg <= 64'h0;
    else if (!reset_busy && ms_tick && upd_ms_reg == prt_pkg::TOTAL_UPDATE_MS - 1)
      grand_reg <= grand_reg + {32'h0, (pend_cnt_reg + total_frac_reg) / total_div_reg};
  end

  // ****************************************************************
  // rate measurement over a one second gate
  // ****************************************************************
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      gate_ms_reg  <= 32'h0;
      gate_cnt_reg <= 32'h0;
      freq_reg     <= 32'h0;
    end
    else if (ms_tick && gate_ms_reg == prt_pkg::RATE_GATE_MS - 1)
    begin
      gate_ms_reg  <= 32'h0;
      gate_cnt_reg <= {31'h0, pulse_edge};
      freq_reg     <= gate_cnt_reg;
    end
    else
    begin
      gate_ms_reg  <= gate_ms_reg + {31'h0, ms_tick};
      gate_cnt_reg <= gate_cnt_reg + {31'h0, pulse_edge};
    end
  end

  // time base multiplier picked from ctrl
  logic [31:0] tb_mul;
  always_comb
  begin
    unique case (ctrl_reg[prt_pkg::CTRL_TB_LSB +: 2])
      prt_pkg::TB_MIN:  tb_mul = prt_pkg::TB_MUL_MIN;
      prt_pkg::TB_HOUR: tb_mul = prt_pkg::TB_MUL_HOUR;
      default:          tb_mul = prt_pkg::TB_MUL_SEC;
    endcase
  end

  // flow disc held on two seconds after each pulse
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      flow_ms_reg <= 32'h0;
    else if (pulse_edge && running)
      flow_ms_reg <= prt_pkg::FLOW_ANIM_MS;
    else if (ms_tick && flow_ms_reg != 32'h0)
      flow_ms_reg <= flow_ms_reg - 32'h1;
  end

  // ****************************************************************
  // display outputs
  // ****************************************************************
  // rate wrapped to its low six digits, total to its low eight
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      rate_display  <= 32'h0;
      total_display <= 32'h0;
      annunciators  <= '0;
    end
    else
    begin
      annunciators.all_segments <= (phase_reg == prt_pkg::PRT_SEG_TEST);
      annunciators.flow         <= (flow_ms_reg != 32'h0) || (phase_reg == prt_pkg::PRT_SEG_TEST);
      annunciators.hold         <= hold || (phase_reg == prt_pkg::PRT_SEG_TEST);
      annunciators.reset        <= reset_busy || (phase_reg == prt_pkg::PRT_SEG_TEST);
      annunciators.grand_total  <= show_gt_lo || show_gt_hi || (phase_reg == prt_pkg::PRT_SEG_TEST);
      if (phase_reg == prt_pkg::PRT_FW_SHOW || show_fw)
        total_display <= prt_pkg::FW_IDENT;
      else if (show_gt_lo)
        total_display <= 32'(grand_reg % 64'd100000000);
      else if (show_gt_hi)
        total_display <= 32'(grand_reg / 64'd100000000);
      else if (running)
        total_display <= total_reg % (10 ** TOTAL_DIGITS);
      else
        total_display <= 32'h0;
      rate_display <= running ? 32'((64'(freq_reg) * 64'(tb_mul) / 64'(rate_div_reg))
                      % (10 ** RATE_DIGITS)) : 32'h0;
    end
  end

  // ****************************************************************
  // apb read
  // ****************************************************************
  always_comb
  begin
    pslverr = 1'b0;
    unique case (paddr)
      prt_pkg::CTRL_OFS:      prdata = ctrl_reg;
      prt_pkg::RATE_DIV_OFS:  prdata = rate_div_reg;
      prt_pkg::TOTAL_DIV_OFS: prdata = total_div_reg;
      prt_pkg::CLIP_OFS:      prdata = clip_reg;
      prt_pkg::STATUS_OFS:    prdata = {27'h0, reset_busy, hold, remote_reset, running, 1'b0};
      prt_pkg::RATE_OFS:      prdata = rate_display;
      prt_pkg::TOTAL_OFS:     prdata = total_reg;
      prt_pkg::GT_LO_OFS:     prdata = grand_reg[31:0];
      prt_pkg::GT_HI_OFS:     prdata = grand_reg[63:32];
      prt_pkg::BTN_MAP_OFS:   prdata = btn_map_reg;
      default:
      begin
        prdata  = 32'h0;
        pslverr = psel && penable;
      end
    endcase
  end

endmodule // prt_core

// file: hdl/prt_pkg.sv
package prt_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam longint CLK_HZ            = 200000000;
  localparam int     SEG_TEST_MS       = 2000;
  localparam int     FW_SHOW_MS        = 2000;
  localparam int     LOCAL_RESET_MS    = 2000;
  localparam int     REMOTE_RESET_MS   = 1000;
  localparam int     FLOW_ANIM_MS      = 2000;
  localparam int     TOTAL_UPDATE_MS   = 500;
  localparam int     RATE_GATE_MS      = 1000;
  localparam int     START_DELAY_MS    = 100;
  localparam int     TICK_MS           = 1;
  // cycles per millisecond tick
  localparam int     TICK_CYCLES       = int'((CLK_HZ * TICK_MS) / 1000);

  // ****************************************************************
  // time base multipliers and codes
  // ****************************************************************
  localparam logic [1:0] TB_SEC  = 2'h0;
  localparam logic [1:0] TB_MIN  = 2'h1;
  localparam logic [1:0] TB_HOUR = 2'h2;
  localparam int         TB_MUL_SEC  = 1;
  localparam int         TB_MUL_MIN  = 60;
  localparam int         TB_MUL_HOUR = 3600;

  // ****************************************************************
  // register map (apb byte addresses)
  // ****************************************************************
  localparam logic [7:0] CTRL_OFS       = 8'h00;
  localparam logic [7:0] RATE_DIV_OFS   = 8'h04;
  localparam logic [7:0] TOTAL_DIV_OFS  = 8'h08;
  localparam logic [7:0] CLIP_OFS       = 8'h0c;
  localparam logic [7:0] STATUS_OFS     = 8'h10;
  localparam logic [7:0] RATE_OFS       = 8'h14;
  localparam logic [7:0] TOTAL_OFS      = 8'h18;
  localparam logic [7:0] GT_LO_OFS      = 8'h1c;
  localparam logic [7:0] GT_HI_OFS      = 8'h20;
  localparam logic [7:0] BTN_MAP_OFS    = 8'h24;

  // ctrl fields
  localparam int CTRL_TB_LSB      = 0;
  localparam int CTRL_LOC_RST_BIT = 2;
  localparam int CTRL_GT_CLR_BIT  = 3;
  localparam int CTRL_ALARM_BIT   = 4;
  localparam int CTRL_PROG_BIT    = 5;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
  localparam logic [31:0] DIV_RESET       = 32'h0000_0001;
  localparam logic [31:0] CLIP_RESET      = 32'h0000_0000;
  localparam logic [31:0] BTN_MAP_RESET   = 32'h0000_0000;

  // identifier shown on the total display; arbitrary value
  localparam logic [31:0] FW_IDENT = 32'h0000_1234;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [2:0] {PRT_PWR_WAIT, PRT_SEG_TEST, PRT_FW_SHOW, PRT_RUN} prt_phase_t;

  typedef struct packed {
    logic up;
    logic down;
    logic commit;
    logic func;
  } prt_buttons_t;

  typedef struct packed {
    logic flow;
    logic hold;
    logic reset;
    logic grand_total;
    logic all_segments;
  } prt_annun_t;

endpackage

// file: sim/prt_chk.sv
`timescale 1ns/1ps
// ********
// port checker
// ********
module prt_chk #(
  parameter int unsigned START_DELAY_MS_P = 1,
  parameter int unsigned TICK_CYCLES_P    = 5
) (
  input wire logic                  ref_clk,
  input wire logic                  rst,
  input wire logic                  pulse_in,
  input wire logic                  remote_reset,
  input wire prt_pkg::prt_buttons_t buttons,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [7:0]            paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic [31:0]           rate_display,
  input wire logic [31:0]           total_display,
  input wire prt_pkg::prt_annun_t   annunciators,
  input wire logic                  running
);
  localparam int T = TICK_CYCLES_P;
  localparam int S = START_DELAY_MS_P;
  int unsigned   pulse_age;
  int unsigned   shut_age;
  int unsigned   boot_age;

  // ages saturate so that long runs never wrap
  always_ff @(posedge ref_clk)
    if (rst || $rose(pulse_in))
      pulse_age <= 0;
    else if (pulse_age < 32'h00ff_ffff)
      pulse_age <= pulse_age + 1;

  // time the remote contact has been closed
  always_ff @(posedge ref_clk)
    if (rst || !remote_reset)
      shut_age <= 0;
    else if (shut_age < 32'h00ff_ffff)
      shut_age <= shut_age + 1;

  // time since release of reset
  always_ff @(posedge ref_clk)
    if (rst)
      boot_age <= 0;
    else if (boot_age < 32'h00ff_ffff)
      boot_age <= boot_age + 1;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence s_access; psel && penable; endsequence
  sequence s_edge; running && $rose(pulse_in); endsequence

  property p_ready; s_access |-> pready; endproperty
  property p_unmapped; (s_access and paddr > 8'h24) |-> pslverr && prdata == 32'h0; endproperty
  property p_reset;
    disable iff (1'b0) rst |=> rate_display == 0 && total_display == 0 && !running;
  endproperty
  property p_seg; annunciators.all_segments |-> !running; endproperty
  property p_boot; $rose(running) |-> boot_age >= (S + 3990) * T && boot_age <= (S + 4010) * T;
  endproperty
  property p_flow_on; s_edge |-> ##[1:4] annunciators.flow; endproperty
  property p_flow_off; $fell(annunciators.flow) |-> pulse_age >= 1999 * T; endproperty
  property p_flow_max; annunciators.flow |-> pulse_age <= 2001 * T + 4; endproperty
  // the segment test lights every annunciator with no button pressed
  property p_gt_ind; annunciators.grand_total && !annunciators.all_segments |->
    $past(buttons.commit || buttons.func) || $past(buttons.commit || buttons.func, 2);
  endproperty
  property p_rst_ind; annunciators.reset && !annunciators.all_segments |->
    $past(remote_reset || (buttons.up && buttons.down))
    || $past(remote_reset || (buttons.up && buttons.down), 2);
  endproperty
  property p_remote; running && shut_age > 1002 * T && !buttons.commit && !buttons.func
    |-> total_display == 0; endproperty
  property p_rate_w; rate_display < 32'h000f_4240; endproperty

  a_ready: assert property (p_ready) else $error("pready low in access");
  a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
  a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
  a_seg: assert property (p_seg) else $error("segment test while running");
  a_boot: assert property (p_boot) else $error("start-up length wrong");
  a_flow_on: assert property (p_flow_on) else $error("pulse did not light flow");
  a_flow_off: assert property (p_flow_off) else $error("flow ended early");
  a_flow_max: assert property (p_flow_max) else $error("flow stayed too long");
  a_gt_ind: assert property (p_gt_ind) else $error("grand total lit unasked");
  a_rst_ind: assert property (p_rst_ind) else $error("reset lit with no reset");
  a_remote: assert property (p_remote) else $error("remote reset left total");
  a_rate_w: assert property (p_rate_w) else $error("rate beyond six digits");
endmodule // prt_chk

bind prt_core prt_chk #(.START_DELAY_MS_P(START_DELAY_MS_P), .TICK_CYCLES_P(TICK_CYCLES_P))
  i_chk (.ref_clk, .rst, .pulse_in, .remote_reset, .buttons, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .rate_display, .total_display,
    .annunciators, .running);

// file: sim/prt_flowmeter.sv
`timescale 1ns/1ps
// ********
// flowmeter model
// ********
module prt_flowmeter (
  input  wire logic        ref_clk,
  input  wire logic        enable,
  input  wire logic [31:0] period,
  output logic             pulse_out = 1'b0
);
  logic [31:0] per_eff;
  logic [31:0] phase;

  // never faster than the fastest input type allows
  assign per_eff = (period < 32'h2) ? 32'h2 : period;

  // one output line: only one terminal pair ever feeds the counter
  always @(posedge ref_clk)
    if (!enable)
    begin
      phase     <= 32'h0;
      pulse_out <= 1'b0;
    end
    else
    begin
      phase     <= (phase + 1 >= per_eff) ? 32'h0 : phase + 1;
      pulse_out <= (phase < per_eff / 2);
    end
endmodule // prt_flowmeter

// file: sim/tb_pulse_rate_totaliser_core.sv
`timescale 1ns/1ps
// ********
// bench top
// ********
module tb_pulse_rate_totaliser_core;
  localparam int T   = 5;
  localparam int PER = 1000 * T / 50;
  logic                  ref_clk = 1'b0;
  logic                  rst = 1'b1;
  logic                  pulse_on = 1'b0;
  logic                  pulse_in;
  logic                  remote_reset = 1'b0;
  prt_pkg::prt_buttons_t buttons = 4'h0;
  logic                  psel = 1'b0;
  logic                  penable = 1'b0;
  logic                  pwrite = 1'b0;
  logic [7:0]            paddr = 8'h00;
  logic [31:0]           pwdata = 32'h0;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic [31:0]           rate_display;
  logic [31:0]           total_display;
  prt_pkg::prt_annun_t   annunciators;
  logic                  running;
  logic                  pulse_q = 1'b0;
  int                    n_pulses = 0;
  int                    fails = 0;
  int                    check_count = 0;
  logic [1:0]            tb_code [3] = '{prt_pkg::TB_SEC, prt_pkg::TB_MIN, prt_pkg::TB_HOUR};
  int                    tb_mul [3] = '{prt_pkg::TB_MUL_SEC, prt_pkg::TB_MUL_MIN,
                                        prt_pkg::TB_MUL_HOUR};

  always #2.5 ref_clk = ~ref_clk;

  prt_flowmeter i_meter (.ref_clk, .enable(pulse_on), .period(32'(PER)), .pulse_out(pulse_in));

  // short tick keeps the multi-second sequences inside the run budget
  prt_core #(.START_DELAY_MS_P(1), .TICK_CYCLES_P(T)) i_dut (.ref_clk, .rst, .pulse_in,
    .remote_reset, .buttons, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rate_display, .total_display, .annunciators, .running);

  // own pulse count, independent of the counter under test
  always @(posedge ref_clk)
  begin
    pulse_q <= pulse_in;
    if (pulse_in && !pulse_q)
      n_pulses <= n_pulses + 1;
  end

  // ********
  // shared tasks
  // ********
  task automatic chk(input bit ok, input string msg);
    check_count++;
    if (!ok)
    begin
      fails++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask

  task automatic print_verdict;
    if (fails == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    int n;
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    q       = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      chk(1'b0, "bus timeout");
      print_verdict();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q === x && e === xe, "register read wrong");
  endtask

  task automatic ms(input int n);
    repeat (n * T) @(posedge ref_clk);
  endtask

  // ********
  // main sequence
  // ********
  initial
  begin
    logic [31:0] q;
    logic [31:0] h;
    logic        e;
    logic [63:0] g;
    int          n;
    int          base;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    chk(running === 1'b0 && total_display === 32'h0, "not idle after reset");
    rdc(prt_pkg::CTRL_OFS, prt_pkg::CTRL_RESET, 1'b0);
    rdc(prt_pkg::RATE_DIV_OFS, prt_pkg::DIV_RESET, 1'b0);
    rdc(prt_pkg::TOTAL_DIV_OFS, prt_pkg::DIV_RESET, 1'b0);
    rdc(prt_pkg::CLIP_OFS, prt_pkg::CLIP_RESET, 1'b0);
    rdc(prt_pkg::BTN_MAP_OFS, prt_pkg::BTN_MAP_RESET, 1'b0);
    rdc(8'h28, 32'h0, 1'b1);
    ms(1000);
    chk(annunciators.all_segments === 1'b1, "segments not lit");
    ms(2000);
    chk(total_display === prt_pkg::FW_IDENT, "ident not shown");
    n = 0;
    while (running !== 1'b1 && n < 1200 * T)
    begin
      @(posedge ref_clk);
      n++;
    end
    @(posedge ref_clk); // display lags the phase by one edge
    chk(running === 1'b1 && total_display === 32'h0, "no start");
    if (running !== 1'b1)
      print_verdict();
    // down with function shows the identifier only while held
    buttons <= 4'h5;
    repeat (4) @(posedge ref_clk);
    chk(total_display === prt_pkg::FW_IDENT, "ident not on buttons");
    buttons <= 4'h0;
    repeat (4) @(posedge ref_clk);
    chk(total_display === 32'h0, "total not back");
    // remote contact: no zero before one second, inhibit after
    pulse_on <= 1'b1;
    ms(600);
    chk(total_display > 0 && total_display <= n_pulses, "no total");
    chk(annunciators.flow === 1'b1, "flow dark");
    remote_reset <= 1'b1;
    ms(900);
    chk(total_display !== 32'h0, "remote zeroed early");
    ms(200);
    chk(total_display === 32'h0 && annunciators.reset === 1'b1, "remote no zero");
    ms(600);
    chk(total_display === 32'h0, "counted while inhibited");
    remote_reset <= 1'b0;
    wr(prt_pkg::TOTAL_DIV_OFS, 32'h4);
    wr(prt_pkg::CTRL_OFS, 32'h20);
    base = n_pulses;
    ms(1000);
    n = (n_pulses - base) / 4;
    chk(total_display <= n && total_display + 8 >= n, "scaled total");
    chk(annunciators.hold === 1'b0, "hold lit at zero clip");
    // every time base, with a divisor each
    for (int i = 0; i < 3; i++)
    begin
      wr(prt_pkg::CTRL_OFS, {30'h0, tb_code[i]});
      wr(prt_pkg::RATE_DIV_OFS, 32'(i + 1));
      ms(2100);
      chk(rate_display >= 49 * tb_mul[i] / (i + 1) && rate_display <= 51 * tb_mul[i] / (i + 1),
          "rate wrong");
    end
    // grand total halves, with the count settled
    pulse_on <= 1'b0;
    ms(600);
    buttons <= 4'h6;
    repeat (4) @(posedge ref_clk);
    apb(1'b0, prt_pkg::GT_LO_OFS, 32'h0, q, e);
    apb(1'b0, prt_pkg::GT_HI_OFS, 32'h0, h, e);
    g = {h, q};
    chk(g !== 64'h0, "grand total empty");
    chk(total_display === 32'(g % 64'd100000000) && annunciators.grand_total === 1'b1,
        "grand low");
    buttons <= 4'ha;
    repeat (4) @(posedge ref_clk);
    chk(total_display === 32'(g / 64'd100000000), "grand high");
    // alarms fitted with remap: up with function acts as commit with down
    wr(prt_pkg::CTRL_OFS, 32'h10);
    wr(prt_pkg::BTN_MAP_OFS, 32'h1);
    buttons <= 4'h9;
    repeat (4) @(posedge ref_clk);
    chk(total_display === 32'(g % 64'd100000000), "remap lost");
    buttons <= 4'h0;
    // local reset needs more than two seconds of up with down
    wr(prt_pkg::CTRL_OFS, 32'h4);
    buttons <= 4'hc;
    ms(1900);
    chk(total_display !== 32'h0 && annunciators.reset === 1'b0, "local early");
    ms(200);
    chk(total_display === 32'h0 && annunciators.reset === 1'b1, "local no zero");
    buttons <= 4'h0;
    // clip-off above the input rate lights hold
    wr(prt_pkg::CLIP_OFS, 32'd1000);
    pulse_on <= 1'b1;
    ms(2100);
    chk(annunciators.hold === 1'b1, "hold dark");
    print_verdict();
  end
endmodule // tb_pulse_rate_totaliser_core
